// ---- hw/msc_map.vh ----
/*
  register indices, reset values, character codes and timing constants of the
  modem configuration register bank. assumes a 50 MHz system clock.
*/
// Function
// - keep 8-bit auto-answer ring threshold, default 2; answer when ring count reaches it
// - threshold of zero means the device never answers on its own
// - read-only ring counter, reset zero, counts detected rings; writes ignored (code counts no rings while answer_out is set, and holds at 255)
// - escape char held, default 43; three consecutive copies form the escape sequence
// - escape value above 127 disables escape detection
// - terminator register character, default 13, ends each command line
// - terminator is appended to every result code sent
// - line-feed char, default 10, is dropped from received command strings
// - line feed follows terminator only with word responses and after a configuration query
// - backspace register character, default 8, acts as backspace while editing
// - blind dialling: wait dial-wait seconds off-hook before first digit
// - non-blind: dial-wait seconds is the maximum wait for dial tone
// - no dial tone by timeout: abandon dialling, report error result
// - after dialling wait carrier-wait seconds for carrier, else hang up
// - each comma in dial string pauses comma-pause seconds
// - configuration query outputs every register, decimal by default
`ifndef MSC_MAP_VH
`define MSC_MAP_VH
`define MSC_IDX_ANSWER    4'h0
`define MSC_IDX_RINGS     4'h1
`define MSC_IDX_ESCAPE    4'h2
`define MSC_IDX_TERM      4'h3
`define MSC_IDX_LF        4'h4
`define MSC_IDX_BS        4'h5
`define MSC_IDX_DIALWAIT  4'h6
`define MSC_IDX_CARRWAIT  4'h7
`define MSC_IDX_COMMA     4'h8
`define MSC_IDX_RSVD      4'h9
`define MSC_IDX_LAST      4'h9
`define MSC_RST_ANSWER    8'h02
`define MSC_RST_RINGS     8'h00
`define MSC_RST_ESCAPE    8'h2B
`define MSC_RST_TERM      8'h0D
`define MSC_RST_LF        8'h0A
`define MSC_RST_BS        8'h08
`define MSC_RST_DIALWAIT  8'h04
`define MSC_RST_CARRWAIT  8'h32
`define MSC_RST_COMMA     8'h02
`define MSC_RST_RSVD      8'h00
`define MSC_ESC_VALID_BIT 7
`define MSC_ESC_REPEAT    2'h3
`define MSC_CLK_HZ        50000000
`define MSC_SEC_CYCLES    (`MSC_CLK_HZ * 1)
`define MSC_CODE_ERROR    8'h34
`define MSC_CHR_COMMA     8'h2C
`define MSC_CHR_COLON     8'h3A
`define MSC_CHR_SPACE     8'h20
`define MSC_CHR_S         8'h53
`define MSC_CHR_ZERO      8'h30
`endif

// ---- hw/msc_second_tick.v ----
/*
  one-second enable divider and seconds down-counter for the dial timers.
  assumes a single system clock; load restarts the count.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msc_map.vh"
module msc_second_tick #(
  parameter SEC_CYCLES = `MSC_SEC_CYCLES
) (
  input  wire       clock_in,
  input  wire       sys_rst_in,
  input  wire       load_in,
  input  wire [7:0] secs_in,
  output reg        expired_out
);
  reg [31:0] div_ff;
  reg [7:0]  left_ff;
  reg        run_ff;
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_ff      <= 32'h0;
      left_ff     <= 8'h00;
      run_ff      <= 1'b0;
      expired_out <= 1'b0;
    end else begin
      expired_out <= 1'b0;
      if (load_in) begin
        div_ff  <= 32'h0;
        left_ff <= secs_in;
        run_ff  <= 1'b1;
        if (secs_in == 8'h00) begin
          run_ff      <= 1'b0;
          expired_out <= 1'b1;
        end
      end else if (run_ff) begin
        if (div_ff == SEC_CYCLES - 1) begin
          div_ff <= 32'h0;
          if (left_ff == 8'h01) begin
            run_ff      <= 1'b0;
            expired_out <= 1'b1;
          end
          left_ff <= left_ff - 8'h01;
        end else begin
          div_ff <= div_ff + 32'h1;
        end
      end
    end
  end
endmodule // msc_second_tick
`default_nettype wire

// ---- hw/msc_config_bank.v ----
/*
  configuration register bank of the modem command interpreter, with the
  character classifier, auto-answer, dial timing and result framing that read it.
  assumes register access by index from the command parser, one clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msc_map.vh"
module msc_config_bank #(
  parameter SEC_CYCLES = `MSC_SEC_CYCLES
) (
  input  wire       clock_in,
  input  wire       sys_rst_in,
  input  wire       reg_wr_in,
  input  wire [3:0] reg_idx_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  input  wire       ring_in,
  output reg        answer_out,
  input  wire       cmd_valid_in,
  input  wire [7:0] cmd_char_in,
  output reg        cmd_valid_out,
  output reg  [7:0] cmd_char_out,
  output reg        cmd_end_out,
  output reg        cmd_bksp_out,
  output reg        escape_out,
  input  wire       blind_dial_in,
  input  wire       dial_start_in,
  input  wire       dial_tone_in,
  input  wire       digits_done_in,
  input  wire       carrier_in,
  input  wire       comma_in,
  output reg        dial_go_out,
  output reg        dial_error_out,
  output reg        hang_up_out,
  output reg        connected_out,
  output reg        dial_busy_out,
  input  wire       word_resp_in,
  input  wire       result_start_in,
  input  wire [7:0] result_code_in,
  input  wire       query_in,
  input  wire       tx_ready_in,
  output reg        tx_valid_out,
  output reg  [7:0] tx_char_out,
  output reg        tx_busy_out
);
  // ************************************************************
  // register file
  // ************************************************************
  wire [7:0] regs_ff [0:9];
  wire       ring_count_up;
  genvar gi;
  generate
    for (gi = 0; gi <= `MSC_IDX_LAST; gi = gi + 1) begin : g_reg
      reg [7:0] cell_ff;
      assign regs_ff[gi] = cell_ff;
      always @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          cell_ff <= (gi == `MSC_IDX_ANSWER)   ? `MSC_RST_ANSWER   :
                     (gi == `MSC_IDX_ESCAPE)   ? `MSC_RST_ESCAPE   :
                     (gi == `MSC_IDX_TERM)     ? `MSC_RST_TERM     :
                     (gi == `MSC_IDX_LF)       ? `MSC_RST_LF       :
                     (gi == `MSC_IDX_BS)       ? `MSC_RST_BS       :
                     (gi == `MSC_IDX_DIALWAIT) ? `MSC_RST_DIALWAIT :
                     (gi == `MSC_IDX_CARRWAIT) ? `MSC_RST_CARRWAIT :
                     (gi == `MSC_IDX_COMMA)    ? `MSC_RST_COMMA    :
                     (gi == `MSC_IDX_RSVD)     ? `MSC_RST_RSVD     :
                     `MSC_RST_RINGS;
        end else if (gi == `MSC_IDX_RINGS) begin
          if (ring_count_up)
            cell_ff <= cell_ff + 8'h01;
        end else if (gi != `MSC_IDX_RSVD && reg_wr_in && reg_idx_in == gi) begin
          cell_ff <= reg_wdata_in;
        end
      end
    end
  endgenerate
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      reg_rdata_out <= 8'h00;
    else if (reg_idx_in <= `MSC_IDX_LAST)
      reg_rdata_out <= regs_ff[reg_idx_in];
    else
      reg_rdata_out <= 8'h00;
  end
  // ************************************************************
  // ring counting and auto-answer
  // ************************************************************
  reg ring_d_ff;
  assign ring_count_up = ring_in & ~ring_d_ff & ~answer_out &
                         (regs_ff[`MSC_IDX_RINGS] != 8'hFF);
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ring_d_ff  <= 1'b0;
      answer_out <= 1'b0;
    end else begin
      ring_d_ff <= ring_in;
      if (regs_ff[`MSC_IDX_ANSWER] != 8'h00 && ring_count_up &&
          regs_ff[`MSC_IDX_RINGS] + 8'h01 >= regs_ff[`MSC_IDX_ANSWER])
        answer_out <= 1'b1;
      else if (dial_start_in)
        answer_out <= 1'b0;
    end
  end
  // ************************************************************
  // command character classification
  // ************************************************************
  reg [1:0] esc_run_ff;
  wire      esc_ok = ~regs_ff[`MSC_IDX_ESCAPE][`MSC_ESC_VALID_BIT];
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cmd_valid_out <= 1'b0;
      cmd_char_out  <= 8'h00;
      cmd_end_out   <= 1'b0;
      cmd_bksp_out  <= 1'b0;
      escape_out    <= 1'b0;
      esc_run_ff    <= 2'h0;
    end else begin
      cmd_valid_out <= 1'b0;
      cmd_end_out   <= 1'b0;
      cmd_bksp_out  <= 1'b0;
      escape_out    <= 1'b0;
      if (cmd_valid_in) begin
        cmd_char_out <= cmd_char_in;
        if (cmd_char_in == regs_ff[`MSC_IDX_TERM])
          cmd_end_out <= 1'b1;
        else if (cmd_char_in == regs_ff[`MSC_IDX_BS])
          cmd_bksp_out <= 1'b1;
        else if (cmd_char_in != regs_ff[`MSC_IDX_LF])
          cmd_valid_out <= 1'b1;
        if (esc_ok && cmd_char_in == regs_ff[`MSC_IDX_ESCAPE]) begin
          if (esc_run_ff == `MSC_ESC_REPEAT - 2'h1) begin
            escape_out <= 1'b1;
            esc_run_ff <= 2'h0;
          end else begin
            esc_run_ff <= esc_run_ff + 2'h1;
          end
        end else begin
          esc_run_ff <= 2'h0;
        end
      end
    end
  end
  // ************************************************************
  // dial sequencing
  // ************************************************************
  localparam D_IDLE = 3'h0;
  localparam D_WAIT = 3'h1;
  localparam D_DIGT = 3'h2;
  localparam D_COMA = 3'h3;
  localparam D_CARR = 3'h4;
  reg [2:0] d_state_ff;
  reg       t_load;
  reg [7:0] t_secs;
  wire      t_exp;
  msc_second_tick #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
    .clock_in    (clock_in),
    .sys_rst_in  (sys_rst_in),
    .load_in     (t_load),
    .secs_in     (t_secs),
    .expired_out (t_exp)
  );
  always @* begin
    t_load = 1'b0;
    t_secs = regs_ff[`MSC_IDX_DIALWAIT];
    case (d_state_ff)
      D_IDLE: begin
        t_load = dial_start_in;
      end
      D_DIGT: begin
        if (comma_in) begin
          t_load = 1'b1;
          t_secs = regs_ff[`MSC_IDX_COMMA];
        end else if (digits_done_in) begin
          t_load = 1'b1;
          t_secs = regs_ff[`MSC_IDX_CARRWAIT];
        end
      end
      default: t_load = 1'b0;
    endcase
  end
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      d_state_ff     <= D_IDLE;
      dial_go_out    <= 1'b0;
      dial_error_out <= 1'b0;
      hang_up_out    <= 1'b0;
      connected_out  <= 1'b0;
      dial_busy_out  <= 1'b0;
    end else begin
      dial_error_out <= 1'b0;
      hang_up_out    <= 1'b0;
      connected_out  <= 1'b0;
      case (d_state_ff)
        D_IDLE: begin
          if (dial_start_in) begin
            d_state_ff    <= D_WAIT;
            dial_busy_out <= 1'b1;
          end
        end
        D_WAIT: begin
          if (!blind_dial_in && dial_tone_in) begin
            d_state_ff  <= D_DIGT;
            dial_go_out <= 1'b1;
          end else if (t_exp) begin
            if (blind_dial_in) begin
              d_state_ff  <= D_DIGT;
              dial_go_out <= 1'b1;
            end else begin
              d_state_ff     <= D_IDLE;
              dial_error_out <= 1'b1;
              hang_up_out    <= 1'b1;
              dial_busy_out  <= 1'b0;
            end
          end
        end
        D_DIGT: begin
          if (comma_in) begin
            d_state_ff  <= D_COMA;
            dial_go_out <= 1'b0;
          end else if (digits_done_in) begin
            d_state_ff  <= D_CARR;
            dial_go_out <= 1'b0;
          end
        end
        D_COMA: begin
          if (t_exp) begin
            d_state_ff  <= D_DIGT;
            dial_go_out <= 1'b1;
          end
        end
        D_CARR: begin
          if (carrier_in) begin
            d_state_ff    <= D_IDLE;
            connected_out <= 1'b1;
            dial_busy_out <= 1'b0;
          end else if (t_exp) begin
            d_state_ff    <= D_IDLE;
            hang_up_out   <= 1'b1;
            dial_busy_out <= 1'b0;
          end
        end
        default: d_state_ff <= D_IDLE;
      endcase
    end
  end
  // ************************************************************
  // result and configuration output framing
  // ************************************************************
  localparam X_IDLE = 3'h0;
  localparam X_CODE = 3'h1;
  localparam X_TERM = 3'h2;
  localparam X_LF   = 3'h3;
  localparam X_QRY  = 3'h4;
  reg [2:0] x_state_ff;
  reg [7:0] code_ff;
  reg [3:0] q_idx_ff;
  reg [2:0] q_pos_ff;
  reg       word_ff;
  wire      step = ~tx_valid_out | tx_ready_in;
  wire [7:0] q_val = regs_ff[q_idx_ff];
  wire [7:0] q_h = q_val / 8'h64;
  wire [7:0] q_t = (q_val / 8'h0A) % 8'h0A;
  wire [7:0] q_u = q_val % 8'h0A;
  reg  [7:0] q_chr;
  always @* begin
    case (q_pos_ff)
      3'h0: q_chr = `MSC_CHR_S;
      3'h1: q_chr = `MSC_CHR_ZERO;
      3'h2: q_chr = `MSC_CHR_ZERO + {4'h0, q_idx_ff};
      3'h3: q_chr = `MSC_CHR_COLON;
      3'h4: q_chr = `MSC_CHR_ZERO + q_h;
      3'h5: q_chr = `MSC_CHR_ZERO + q_t;
      3'h6: q_chr = `MSC_CHR_ZERO + q_u;
      default: q_chr = `MSC_CHR_SPACE;
    endcase
  end
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      x_state_ff   <= X_IDLE;
      code_ff      <= 8'h00;
      q_idx_ff     <= 4'h0;
      q_pos_ff     <= 3'h0;
      word_ff      <= 1'b0;
      tx_valid_out <= 1'b0;
      tx_char_out  <= 8'h00;
      tx_busy_out  <= 1'b0;
    end else if (step) begin
      tx_valid_out <= 1'b0;
      case (x_state_ff)
        X_IDLE: begin
          tx_busy_out <= 1'b0;
          word_ff     <= word_resp_in;
          if (query_in) begin
            x_state_ff  <= X_QRY;
            q_idx_ff    <= 4'h0;
            q_pos_ff    <= 3'h0;
            tx_busy_out <= 1'b1;
          end else if (result_start_in || dial_error_out) begin
            x_state_ff  <= X_CODE;
            code_ff     <= dial_error_out ? `MSC_CODE_ERROR : result_code_in;
            tx_busy_out <= 1'b1;
          end
        end
        X_CODE: begin
          tx_valid_out <= 1'b1;
          tx_char_out  <= code_ff;
          x_state_ff   <= X_TERM;
        end
        X_TERM: begin
          tx_valid_out <= 1'b1;
          tx_char_out  <= regs_ff[`MSC_IDX_TERM];
          x_state_ff   <= word_ff ? X_LF : X_IDLE;
        end
        X_LF: begin
          tx_valid_out <= 1'b1;
          tx_char_out  <= regs_ff[`MSC_IDX_LF];
          x_state_ff   <= X_IDLE;
        end
        X_QRY: begin
          tx_valid_out <= 1'b1;
          tx_char_out  <= q_chr;
          q_pos_ff     <= q_pos_ff + 3'h1;
          if (q_pos_ff == 3'h7) begin
            q_idx_ff <= q_idx_ff + 4'h1;
            if (q_idx_ff == `MSC_IDX_LAST) begin
              x_state_ff <= X_TERM;
              word_ff    <= 1'b1;
            end
          end
        end
        default: x_state_ff <= X_IDLE;
      endcase
    end
  end
endmodule // msc_config_bank
`default_nettype wire

// ---- tb/msc_config_bank_asserts.sv ----
/*
  port checker of the configuration bank, bound to every msc_config_bank.
  assumes one clock and the register defaults of msc_map.vh.
*/
`timescale 1ns/100ps
`default_nettype none
`include "msc_map.vh"
module msc_config_bank_asserts #(
  parameter SEC_CYCLES = 10
) (
  input wire logic       clock_in,
  input wire logic       sys_rst_in,
  input wire logic       reg_wr_in,
  input wire logic [3:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       answer_out,
  input wire logic       cmd_valid_in,
  input wire logic [7:0] cmd_char_in,
  input wire logic       cmd_valid_out,
  input wire logic [7:0] cmd_char_out,
  input wire logic       cmd_end_out,
  input wire logic       cmd_bksp_out,
  input wire logic       escape_out,
  input wire logic       tx_ready_in,
  input wire logic       tx_valid_out,
  input wire logic [7:0] tx_char_out
);
  // ****
  // shadow of the character and threshold registers
  // ****
  logic [7:0] sh_ff [0:5];
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sh_ff[0] <= `MSC_RST_ANSWER;
      sh_ff[1] <= `MSC_RST_RINGS;
      sh_ff[2] <= `MSC_RST_ESCAPE;
      sh_ff[3] <= `MSC_RST_TERM;
      sh_ff[4] <= `MSC_RST_LF;
      sh_ff[5] <= `MSC_RST_BS;
    end else if (reg_wr_in && reg_idx_in < 4'h6) begin
      sh_ff[reg_idx_in[2:0]] <= reg_wdata_in;
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  property p_rsvd_zero;
    reg_idx_in >= 4'h9 |=> reg_rdata_out == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");
  property p_wr_read;
    reg_wr_in && reg_idx_in == 4'h6 ##1 !reg_wr_in && $stable(reg_idx_in)
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_wr_read: assert property (p_wr_read) else $error("dial wait readback wrong");
  property p_no_auto;
    sh_ff[0] == 8'h00 |=> !$rose(answer_out);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("answered with zero threshold");
  property p_esc;
    escape_out |-> $past(cmd_valid_in) && $past(cmd_char_in) == sh_ff[2] && !sh_ff[2][7];
  endproperty
  a_esc: assert property (p_esc) else $error("escape without cause");
  property p_term;
    cmd_valid_in && cmd_char_in == sh_ff[3] |=> cmd_end_out && !cmd_valid_out;
  endproperty
  a_term: assert property (p_term) else $error("terminator not seen");
  property p_lf;
    cmd_valid_in && cmd_char_in == sh_ff[4] |=> !cmd_valid_out && !cmd_end_out;
  endproperty
  a_lf: assert property (p_lf) else $error("line feed passed");
  property p_bs;
    cmd_valid_in && cmd_char_in == sh_ff[5] |=> cmd_bksp_out && !cmd_valid_out;
  endproperty
  a_bs: assert property (p_bs) else $error("backspace not seen");
  property p_pass;
    cmd_valid_in && cmd_char_in != sh_ff[2] && cmd_char_in != sh_ff[3]
      && cmd_char_in != sh_ff[4] && cmd_char_in != sh_ff[5]
      |=> cmd_valid_out && cmd_char_out == $past(cmd_char_in);
  endproperty
  a_pass: assert property (p_pass) else $error("ordinary char lost");
  property p_tx_hold;
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_char_out);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx char dropped");
endmodule // msc_config_bank_asserts
bind msc_config_bank msc_config_bank_asserts #(.SEC_CYCLES(SEC_CYCLES)) i_chk (
  .clock_in      (clock_in),
  .sys_rst_in    (sys_rst_in),
  .reg_wr_in     (reg_wr_in),
  .reg_idx_in    (reg_idx_in),
  .reg_wdata_in  (reg_wdata_in),
  .reg_rdata_out (reg_rdata_out),
  .answer_out    (answer_out),
  .cmd_valid_in  (cmd_valid_in),
  .cmd_char_in   (cmd_char_in),
  .cmd_valid_out (cmd_valid_out),
  .cmd_char_out  (cmd_char_out),
  .cmd_end_out   (cmd_end_out),
  .cmd_bksp_out  (cmd_bksp_out),
  .escape_out    (escape_out),
  .tx_ready_in   (tx_ready_in),
  .tx_valid_out  (tx_valid_out),
  .tx_char_out   (tx_char_out)
);
`default_nettype wire

// ---- tb/msc_tx_sink.sv ----
/*
  host serial sink model: stalls two cycles of three, queues accepted chars.
  assumes chars are held by the sender until accepted.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_tx_sink (
  input  wire logic       clock_in,
  input  wire logic       sys_rst_in,
  input  wire logic       valid_in,
  input  wire logic [7:0] char_in,
  output var  logic       ready_out
);
  logic [1:0] stall_ff;
  logic [7:0] rx_q [$];
  initial stall_ff = 2'h0;
  initial ready_out = 1'b0;
  always @(negedge clock_in) begin
    stall_ff = (stall_ff == 2'h2) ? 2'h0 : stall_ff + 2'h1;
    ready_out = !sys_rst_in && stall_ff == 2'h0;
  end
  always @(posedge clock_in) begin
    if (valid_in && ready_out) rx_q.push_back(char_in);
  end
endmodule // msc_tx_sink
`default_nettype wire

// ---- tb/msc_config_bank_test.sv ----
/*
  self-checking bench of msc_config_bank with a stalling host sink.
  assumes SEC_CYCLES shortened so one second is SEC clocks.
*/
`timescale 1ns/100ps
`default_nettype none
module msc_config_bank_test;
  localparam int SEC = 10;
  logic       clock_in, sys_rst_in, reg_wr_in, ring_in, cmd_valid_in, blind_dial_in;
  logic       dial_start_in, dial_tone_in, digits_done_in, carrier_in, comma_in;
  logic       word_resp_in, result_start_in, query_in, tx_ready_in, answer_out;
  logic       cmd_valid_out, cmd_end_out, cmd_bksp_out, escape_out, dial_go_out;
  logic       dial_error_out, hang_up_out, connected_out, dial_busy_out;
  logic       tx_valid_out, tx_busy_out;
  logic [3:0] reg_idx_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, cmd_char_in, cmd_char_out;
  logic [7:0] result_code_in, tx_char_out;
  logic [7:0] dflt [0:10] = '{8'h02, 8'h00, 8'h2B, 8'h0D, 8'h0A, 8'h08, 8'h04, 8'h32,
                              8'h02, 8'h00, 8'h00};
  string      qs = "S00:000 ";
  int         errors = 0, tests_run = 0, n, i;
  msc_config_bank #(.SEC_CYCLES(SEC)) i_msc_config_bank (
    .clock_in        (clock_in),
    .sys_rst_in      (sys_rst_in),
    .reg_wr_in       (reg_wr_in),
    .reg_idx_in      (reg_idx_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_rdata_out   (reg_rdata_out),
    .ring_in         (ring_in),
    .answer_out      (answer_out),
    .cmd_valid_in    (cmd_valid_in),
    .cmd_char_in     (cmd_char_in),
    .cmd_valid_out   (cmd_valid_out),
    .cmd_char_out    (cmd_char_out),
    .cmd_end_out     (cmd_end_out),
    .cmd_bksp_out    (cmd_bksp_out),
    .escape_out      (escape_out),
    .blind_dial_in   (blind_dial_in),
    .dial_start_in   (dial_start_in),
    .dial_tone_in    (dial_tone_in),
    .digits_done_in  (digits_done_in),
    .carrier_in      (carrier_in),
    .comma_in        (comma_in),
    .dial_go_out     (dial_go_out),
    .dial_error_out  (dial_error_out),
    .hang_up_out     (hang_up_out),
    .connected_out   (connected_out),
    .dial_busy_out   (dial_busy_out),
    .word_resp_in    (word_resp_in),
    .result_start_in (result_start_in),
    .result_code_in  (result_code_in),
    .query_in        (query_in),
    .tx_ready_in     (tx_ready_in),
    .tx_valid_out    (tx_valid_out),
    .tx_char_out     (tx_char_out),
    .tx_busy_out     (tx_busy_out)
  );
  msc_tx_sink i_msc_tx_sink (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .valid_in(tx_valid_out), .char_in(tx_char_out), .ready_out(tx_ready_in));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  // ****
  // tasks
  // ****
  task automatic final_report;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic give_up;
    errors++;
    final_report();
  endtask
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    check8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_wr_in = 1'b1;
    reg_idx_in = a;
    reg_wdata_in = d;
    @(negedge clock_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge clock_in);
    reg_idx_in = a;
    @(negedge clock_in);
    check8("reg_rdata_out", e, reg_rdata_out);
  endtask
  task automatic pulse(input int s);
    @(negedge clock_in);
    case (s)
      0: dial_start_in = 1'b1;
      1: digits_done_in = 1'b1;
      2: comma_in = 1'b1;
      3: result_start_in = 1'b1;
      4: query_in = 1'b1;
      default: ring_in = 1'b1;
    endcase
    @(negedge clock_in);
    {dial_start_in, digits_done_in, comma_in, result_start_in, query_in, ring_in} = 6'h00;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return dial_go_out;
      1: return dial_error_out;
      2: return hang_up_out;
      3: return connected_out;
      default: return !tx_busy_out;
    endcase
  endfunction
  task automatic wait_on(input int s, input int lim, output int k);
    for (k = 0; pick(s) !== 1'b1; k++) begin
      if (k == lim) give_up();
      @(negedge clock_in);
    end
  endtask
  task automatic expect_tx(input logic [7:0] c);
    int k;
    for (k = 0; i_msc_tx_sink.rx_q.size() == 0; k++) begin
      if (k == 300) give_up();
      @(negedge clock_in);
    end
    check8("tx_char_out", c, i_msc_tx_sink.rx_q.pop_front());
  endtask
  task automatic send(input logic [7:0] c, input logic [3:0] e, input logic [3:0] m);
    @(negedge clock_in);
    cmd_valid_in = 1'b1;
    cmd_char_in = c;
    @(negedge clock_in);
    cmd_valid_in = 1'b0;
    check8("cmd_flags", {4'h0, e},
           {4'h0, m & {escape_out, cmd_end_out, cmd_bksp_out, cmd_valid_out}});
  endtask
  function automatic logic near(input int k, input int s);
    return k >= s * SEC - 3 && k <= s * SEC + 3;
  endfunction
  // ****
  // main sequence
  // ****
  initial begin
    {reg_wr_in, ring_in, cmd_valid_in, blind_dial_in, dial_start_in, dial_tone_in} = 6'h00;
    {digits_done_in, carrier_in, comma_in, word_resp_in, result_start_in, query_in} = 6'h00;
    {reg_idx_in, reg_wdata_in, cmd_char_in, result_code_in} = 28'h000_0000;
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    for (i = 0; i < 11; i++) rd(i[3:0], dflt[i]);
    wr(4'h1, 8'hFF);
    wr(4'h9, 8'hFF);
    wr(4'h6, 8'h02);
    wr(4'h7, 8'h03);
    wr(4'h8, 8'h01);
    rd(4'h1, 8'h00);
    rd(4'h9, 8'h00);
    rd(4'h6, 8'h02);
    pulse(5);
    check1("answer_out", 1'b0, answer_out);
    pulse(5);
    pulse(5);
    repeat (2) @(negedge clock_in);
    check1("answer_out", 1'b1, answer_out);
    rd(4'h1, 8'h02);
    blind_dial_in = 1'b1;
    pulse(0);
    wait_on(0, 100, n);
    check1("blind_wait", 1'b1, near(n, 2));
    check1("answer_out", 1'b0, answer_out);
    pulse(2);
    check1("dial_go_out", 1'b0, dial_go_out);
    check1("dial_busy_out", 1'b1, dial_busy_out);
    wait_on(0, 100, n);
    check1("comma_wait", 1'b1, near(n, 1));
    pulse(1);
    wait_on(2, 200, n);
    check1("carrier_wait", 1'b1, near(n, 3));
    check1("dial_busy_out", 1'b0, dial_busy_out);
    pulse(0);
    wait_on(0, 100, n);
    pulse(1);
    carrier_in = 1'b1;
    wait_on(3, 20, n);
    check1("connected_out", 1'b1, connected_out);
    carrier_in = 1'b0;
    blind_dial_in = 1'b0;
    word_resp_in = 1'b1;
    pulse(0);
    wait_on(1, 100, n);
    check1("tone_wait", 1'b1, near(n, 2));
    expect_tx(8'h34);
    expect_tx(8'h0D);
    expect_tx(8'h0A);
    wr(4'h0, 8'h00);
    repeat (3) pulse(5);
    repeat (2) @(negedge clock_in);
    check1("answer_out", 1'b0, answer_out);
    send(8'h41, 4'h1, 4'hF);
    send(8'h0D, 4'h4, 4'hF);
    send(8'h08, 4'h2, 4'hF);
    send(8'h0A, 4'h0, 4'hF);
    send(8'h2B, 4'h0, 4'h8);
    send(8'h2B, 4'h0, 4'h8);
    send(8'h2B, 4'h8, 4'h8);
    wr(4'h2, 8'hAB);
    for (i = 0; i < 3; i++) send(8'hAB, 4'h0, 4'h8);
    wr(4'h3, 8'h21);
    send(8'h21, 4'h4, 4'hF);
    send(8'h0D, 4'h1, 4'hF);
    word_resp_in = 1'b0;
    result_code_in = 8'h30;
    pulse(3);
    expect_tx(8'h30);
    expect_tx(8'h21);
    wait_on(4, 100, n);
    check1("no_line_feed", 1'b1, i_msc_tx_sink.rx_q.size() == 0);
    pulse(4);
    for (i = 0; i < 8; i++) expect_tx(qs[i]);
    wait_on(4, 2000, n);
    final_report();
  end
endmodule // msc_config_bank_test
`default_nettype wire
